// *** rtl/cmpc_pkg.sv ***
/*
 * cmpc_pkg: register map, field positions and reset values for the
 * comparator control block.
 * Assumes a 32-bit APB bus with one aligned word per register.
 */
`default_nettype none
package cmpc_pkg;
    // printed offsets are register indices; byte address is four times
    localparam int          IDX_CTRL    = 0;
    localparam int          IDX_INSEL   = 2;
    localparam int          IDX_IRQEN   = 6;
    localparam int          IDX_STATUS  = 7;
    localparam logic [11:0] ADDR_CTRL   = 12'(IDX_CTRL * 4);
    localparam logic [11:0] ADDR_INSEL  = 12'(IDX_INSEL * 4);
    localparam logic [11:0] ADDR_IRQEN  = 12'(IDX_IRQEN * 4);
    localparam logic [11:0] ADDR_STATUS = 12'(IDX_STATUS * 4);
    // control register fields
    localparam int BIT_STDBY_RUN  = 7;
    localparam int BIT_PAD_OE     = 6;
    localparam int BIT_EDGE_HI    = 5;
    localparam int BIT_EDGE_LO    = 4;
    localparam int BIT_LOW_POWER  = 3;
    localparam int BIT_HYST_HI    = 2;
    localparam int BIT_HYST_LO    = 1;
    localparam int BIT_ENABLE     = 0;
    // input select fields
    localparam int BIT_INVERT     = 7;
    localparam int BIT_NEG_HI     = 1;
    localparam int BIT_NEG_LO     = 0;
    // irq enable and status fields
    localparam int BIT_IRQ        = 0;
    localparam int BIT_STATE      = 4;
    // writable masks and reset value
    localparam logic [7:0] MASK_CTRL  = 8'hff;
    localparam logic [7:0] MASK_INSEL = 8'h83;
    localparam logic [7:0] MASK_IRQEN = 8'h01;
    localparam logic [7:0] RESET_VAL  = 8'h00;
    // edge select encodings
    localparam logic [1:0] EDGE_ANY     = 2'h0;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_RISING  = 2'h3;
    // synchroniser depth, result visible in the state bit after 4 cycles
    localparam int SYNC_CYCLES = 3;
endpackage : cmpc_pkg
`default_nettype wire

// *** rtl/cmpc_top.sv ***
/*
 * cmpc_top: APB register bank, result synchroniser and edge flag for an
 * analog comparator core.
 * Assumes the analog core delivers one asynchronous raw result bit and
 * that a power manager reports standby and power-down sleep as levels
 * synchronous to i_clk; in standby without i_clk the gated clock stops.
 */
`default_nettype none
// Overview of operation
// - standby-run set: comparator runs in standby, flag and state frozen
// - standby-run clear: comparator halted throughout standby sleep
// - pad-output enable drives result to pin, else pin undriven
// - edge select: 0 both edges, 2 falling, 3 rising, 1 reserved
// - low-power bit asserts reduced-current control to the core
// - hysteresis field passed to core: off, 10, 25, 50 mV
// - control bit 0 enables the comparator
// - invert bit inverts result for pin, event, state and edges
// - positive input select 0 means positive pin zero only
// - negative select: 0 pin, 2 reference, 3 converter, 1 reserved
// - irq-enable bit 0 gates the comparator interrupt
// - state bit mirrors synced result, visible after 4 cycles
// - writing one clears the irq flag, zero leaves it
// - all four registers reset to zero
// - irq request held while enable and flag both set
// - raw result is one when positive input exceeds negative
// - power-down sleep disables comparator and pad output
// - standby running keeps event and pad output updating
module cmpc_top (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire logic [3:0]  i_pstrb,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic [31:0]      o_prdata,
    // sleep state from power manager
    input  wire logic        i_standby,
    input  wire logic        i_power_down,
    // analog core
    input  wire logic        i_raw_result,
    output logic             o_core_enable,
    output logic             o_reduced_current_select,
    output logic [1:0]       o_hysteresis_level,
    output logic             o_positive_pin_zero_sel,
    output logic [1:0]       o_negative_input_select,
    // result consumers
    output logic             o_pad_out,
    output logic             o_pad_oe,
    output logic             o_event,
    output logic             o_irq
);
    // reset release synchroniser
    logic rst_meta_q;
    logic rst_sync_q;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    wire logic rst_n = rst_sync_q;

    // registers and synchroniser state
    logic [7:0] ctrl_q, ctrl_d;
    logic [7:0] insel_q, insel_d;
    logic [7:0] irqen_q, irqen_d;
    logic       flag_q, flag_d;
    logic       state_q, state_d;
    logic       sync1_q, sync2_q, sync3_q;
    logic       prev_q, prev_d;
    logic       prev_vld_q, prev_vld_d;
    logic [31:0] rdata_q, rdata_d;

    // bus decode shared by reads and writes
    function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
        hit = (a == r);
    endfunction : hit

    wire logic wr_en  = i_psel & i_penable & i_pwrite;
    wire logic rd_set = i_psel & ~i_penable & ~i_pwrite;
    wire logic lane0  = i_pstrb[0];

    // comparator is live when enabled and sleep does not halt it
    logic active;
    always_comb begin
        active = ctrl_q[cmpc_pkg::BIT_ENABLE]
               & ~i_power_down
               & ~(i_standby & ~ctrl_q[cmpc_pkg::BIT_STDBY_RUN]);
    end
    // flag and state freeze while standby stops the peripheral clock
    wire logic frozen = i_standby;

    // core controls, only core enable held off when not active
    assign o_core_enable            = active;
    assign o_reduced_current_select =
        ctrl_q[cmpc_pkg::BIT_LOW_POWER];
    assign o_hysteresis_level       =
        ctrl_q[cmpc_pkg::BIT_HYST_HI:cmpc_pkg::BIT_HYST_LO];
    assign o_positive_pin_zero_sel  = 1'b1;
    assign o_negative_input_select  =
        insel_q[cmpc_pkg::BIT_NEG_HI:cmpc_pkg::BIT_NEG_LO];

    // raw result sync; core drives one when positive exceeds negative
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= i_raw_result;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    // post-inversion result seen by every consumer
    wire logic result =
        (sync3_q ^ insel_q[cmpc_pkg::BIT_INVERT]) & active;

    // pad and event keep updating in standby-run, pin off in power down
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_pad_out <= 1'b0;
            o_pad_oe  <= 1'b0;
            o_event   <= 1'b0;
        end else begin
            o_pad_out <= result;
            o_pad_oe  <= ctrl_q[cmpc_pkg::BIT_PAD_OE]
                       & ~i_power_down;
            o_event   <= result;
        end
    end

    // edge detect and flag next-state
    logic rise, fall, edge_hit;
    always_comb begin
        prev_d     = prev_q;
        prev_vld_d = prev_vld_q;
        state_d    = state_q;
        flag_d     = flag_q;
        rise       = 1'b0;
        fall       = 1'b0;
        edge_hit   = 1'b0;
        if (!active) begin
            prev_vld_d = 1'b0;
        end else if (!frozen) begin
            prev_d     = result;
            prev_vld_d = 1'b1;
            rise = prev_vld_q & result & ~prev_q;
            fall = prev_vld_q & ~result & prev_q;
            case (ctrl_q[cmpc_pkg::BIT_EDGE_HI:cmpc_pkg::BIT_EDGE_LO])
                cmpc_pkg::EDGE_ANY:     edge_hit = rise | fall;
                cmpc_pkg::EDGE_FALLING: edge_hit = fall;
                cmpc_pkg::EDGE_RISING:  edge_hit = rise;
                default:                edge_hit = 1'b0;
            endcase
        end
        if (!frozen) begin
            state_d = result;
        end
        // write-one clear, a same-cycle edge wins
        if (wr_en && lane0 && hit(i_paddr, cmpc_pkg::ADDR_STATUS)
            && i_pwdata[cmpc_pkg::BIT_IRQ]) begin
            flag_d = 1'b0;
        end
        if (edge_hit) begin
            flag_d = 1'b1;
        end
    end

    // register writes, only the low lane carries the 8-bit registers
    always_comb begin
        ctrl_d  = ctrl_q;
        insel_d = insel_q;
        irqen_d = irqen_q;
        if (wr_en && lane0) begin
            if (hit(i_paddr, cmpc_pkg::ADDR_CTRL)) begin
                ctrl_d = i_pwdata[7:0] & cmpc_pkg::MASK_CTRL;
            end
            if (hit(i_paddr, cmpc_pkg::ADDR_INSEL)) begin
                insel_d = i_pwdata[7:0] & cmpc_pkg::MASK_INSEL;
            end
            if (hit(i_paddr, cmpc_pkg::ADDR_IRQEN)) begin
                irqen_d = i_pwdata[7:0] & cmpc_pkg::MASK_IRQEN;
            end
        end
    end

    // read data captured in the setup cycle
    always_comb begin
        rdata_d = rdata_q;
        if (rd_set) begin
            rdata_d = 32'h0000_0000;
            if (hit(i_paddr, cmpc_pkg::ADDR_CTRL)) begin
                rdata_d[7:0] = ctrl_q;
            end
            if (hit(i_paddr, cmpc_pkg::ADDR_INSEL)) begin
                rdata_d[7:0] = insel_q;
            end
            if (hit(i_paddr, cmpc_pkg::ADDR_IRQEN)) begin
                rdata_d[7:0] = irqen_q;
            end
            if (hit(i_paddr, cmpc_pkg::ADDR_STATUS)) begin
                rdata_d[cmpc_pkg::BIT_STATE] = state_q;
                rdata_d[cmpc_pkg::BIT_IRQ]   = flag_q;
            end
        end
    end

    // state registers
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q     <= cmpc_pkg::RESET_VAL;
            insel_q    <= cmpc_pkg::RESET_VAL;
            irqen_q    <= cmpc_pkg::RESET_VAL;
            flag_q     <= 1'b0;
            state_q    <= 1'b0;
            prev_q     <= 1'b0;
            prev_vld_q <= 1'b0;
            rdata_q    <= 32'h0000_0000;
        end else begin
            ctrl_q     <= ctrl_d;
            insel_q    <= insel_d;
            irqen_q    <= irqen_d;
            flag_q     <= flag_d;
            state_q    <= state_d;
            prev_q     <= prev_d;
            prev_vld_q <= prev_vld_d;
            rdata_q    <= rdata_d;
        end
    end

    // apb answers in the first access cycle, never errors
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_prdata  = rdata_q;
    // irq is a level held while the flag and its enable bit are both set
    assign o_irq = flag_q & irqen_q[cmpc_pkg::BIT_IRQ];

    // assertions
    a_irq_level: assert property (@(posedge i_clk) disable iff (!rst_n)
        o_irq == (flag_q & irqen_q[0]))
        else $error("irq does not follow flag and enable");
    a_flag_clear: assert property (@(posedge i_clk) disable iff (!rst_n)
        (wr_en && lane0 && i_paddr == cmpc_pkg::ADDR_STATUS && i_pwdata[0]
         && !edge_hit) |=> !flag_q)
        else $error("flag not cleared by write one");
    a_flag_hold: assert property (@(posedge i_clk) disable iff (!rst_n)
        (flag_q && !(wr_en && i_paddr == cmpc_pkg::ADDR_STATUS)) |=> flag_q)
        else $error("flag lost without clear");
    a_state_delay: assert property (@(posedge i_clk) disable iff (!rst_n)
        (active && !frozen && $stable(insel_q) && $stable(active))
        |=> state_q == ($past(sync3_q) ^ $past(insel_q[7])))
        else $error("state bit not mirroring result");
    a_rise_only: assert property (@(posedge i_clk) disable iff (!rst_n)
        (ctrl_q[5:4] == 2'h3 && fall) |=> $stable(flag_q) || !flag_q
        || $past(flag_q))
        else $error("falling edge set flag in rising mode");
    a_reserved_edge: assert property (@(posedge i_clk) disable iff (!rst_n)
        (ctrl_q[5:4] == 2'h1) |-> !edge_hit)
        else $error("reserved edge mode triggered");
    a_pd_pad: assert property (@(posedge i_clk) disable iff (!rst_n)
        i_power_down |=> !o_pad_oe)
        else $error("pad driven in power down");
    a_disabled_edge: assert property (@(posedge i_clk) disable iff (!rst_n)
        !active |-> !edge_hit && !o_core_enable)
        else $error("edge seen while disabled");
    a_frozen_state: assert property (@(posedge i_clk) disable iff (!rst_n)
        frozen |=> $stable(state_q))
        else $error("state updated in standby");
endmodule : cmpc_top
`default_nettype wire

// *** dv/cmpc_core_model.sv ***
/*
 * cmpc_core_model: behavioural analog comparator core.
 * Assumes the bench gives both input levels as plain codes.
 */
`default_nettype none
module cmpc_core_model (
    // control from block
    input  wire logic       i_clk,
    input  wire logic       i_enable,
    // input levels from bench
    input  wire logic [7:0] i_pos,
    input  wire logic [7:0] i_neg,
    // raw result to block
    output logic            o_raw
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_q = 1'b0;
    // a halted core gives no valid answer, so its output wanders
    always @(posedge i_clk) junk_q <= ~junk_q;
    // one when the positive input is above the negative
    assign o_raw = i_enable ? (i_pos > i_neg) : junk_q;
endmodule : cmpc_core_model
`default_nettype wire

// *** dv/testbench.sv ***
/*
 * testbench: drives the comparator control block over apb and the
 * core model, reads back registers and watches pin and irq outputs.
 * Assumes the block answers apb reads in the access phase.
 */
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, psel, pen, pwr, sb, pd, raw, u, inv, f;
    logic        prdy, slverr, core_en, lp, ppz, pad, oe, ev, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d;
    logic [3:0]  pstrb;
    logic [7:0]  pos, neg, e;
    logic [1:0]  hys, nsel, m;
    logic [7:0]  expq[$];
    int          errors = 0;
    int          checked = 0;
    logic [1:0]  modes[3] = '{cmpc_pkg::EDGE_ANY, cmpc_pkg::EDGE_FALLING,
                              cmpc_pkg::EDGE_RISING};
    logic [11:0] addrs[5] = '{cmpc_pkg::ADDR_CTRL, cmpc_pkg::ADDR_INSEL,
                              cmpc_pkg::ADDR_IRQEN, cmpc_pkg::ADDR_STATUS,
                              12'h004};

    cmpc_top cmpc_top_inst (
        .i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_pready(prdy), .o_pslverr(slverr),
        .o_prdata(prdata), .i_standby(sb), .i_power_down(pd),
        .i_raw_result(raw), .o_core_enable(core_en),
        .o_reduced_current_select(lp), .o_hysteresis_level(hys),
        .o_positive_pin_zero_sel(ppz), .o_negative_input_select(nsel),
        .o_pad_out(pad), .o_pad_oe(oe), .o_event(ev), .o_irq(irq));
    cmpc_core_model cmpc_core_model_inst (
        .i_clk(clk), .i_enable(core_en), .i_pos(pos), .i_neg(neg),
        .o_raw(raw));

    // one apb transfer; a read leaves its expected byte in the queue
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] dat, input logic [7:0] ex);
        @(posedge clk);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= dat;
        if (!w) expq.push_back(ex);
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (prdy !== 1'b1) @(posedge clk);
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] dat);
        apb(1'b1, a, dat, 8'h00);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [7:0] ex);
        apb(1'b0, a, 32'h0, ex);
    endtask : rd
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // read data is judged at the edge the master takes it
    always @(posedge clk) begin
        if (psel && pen && !pwr && prdy === 1'b1) begin
            e = expq.pop_front();
            `CHK(prdata, {24'h0, e})
            `CHK(slverr, 1'b0)
        end
    end
    // clock, 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // bounds a hang well beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; sb = 1'b0;
        pd = 1'b0; paddr = 12'h0; pwdata = 32'h0; pstrb = 4'hf;
        pos = 8'h10; neg = 8'h20;
        void'($urandom(89490));
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (addrs[i]) rd(addrs[i], 8'h00);
        `CHK(core_en, 1'b0)
        `CHK(ppz, 1'b1)
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            wr(cmpc_pkg::ADDR_CTRL, d);
            rd(cmpc_pkg::ADDR_CTRL, d[7:0]);
            `CHK(hys, d[2:1])
            `CHK(lp, d[3])
            wr(cmpc_pkg::ADDR_INSEL, d);
            rd(cmpc_pkg::ADDR_INSEL, d[7:0] & 8'h83);
            `CHK(nsel, d[1:0])
            wr(cmpc_pkg::ADDR_IRQEN, d);
            rd(cmpc_pkg::ADDR_IRQEN, d[7:0] & 8'h01);
            wr(12'h004, d);
            rd(12'h004, 8'h00);
        end
        $display("test registers done");
        // any, falling and rising edge modes, with and without inversion, rise then fall
        foreach (modes[j]) for (int v = 0; v < 2; v++) begin
            m = modes[j];
            inv = v[0];
            pos <= 8'h10;
            wr(cmpc_pkg::ADDR_CTRL, 32'h0);
            wr(cmpc_pkg::ADDR_INSEL, {24'h0, inv, 7'h0});
            wr(cmpc_pkg::ADDR_CTRL, {26'h0, m, 4'h1});
            wr(cmpc_pkg::ADDR_IRQEN, 32'h1);
            repeat (8) @(posedge clk);
            wr(cmpc_pkg::ADDR_STATUS, 32'h1);
            for (int k = 0; k < 2; k++) begin
                u = (k == 0);
                pos <= u ? 8'h30 : 8'h10;
                repeat (8) @(posedge clk);
                f = (m == cmpc_pkg::EDGE_ANY) ||
                    ((m == cmpc_pkg::EDGE_RISING) == (u ^ inv));
                wr(cmpc_pkg::ADDR_STATUS, 32'h0);
                rd(cmpc_pkg::ADDR_STATUS, {3'h0, u ^ inv, 3'h0, f});
                `CHK(irq, f)
                wr(cmpc_pkg::ADDR_STATUS, 32'h1);
                rd(cmpc_pkg::ADDR_STATUS, {3'h0, u ^ inv, 4'h0});
            end
        end
        $display("test edges done");
        wr(cmpc_pkg::ADDR_CTRL, 32'h41);
        wr(cmpc_pkg::ADDR_INSEL, 32'h80);
        pos <= 8'h30;
        repeat (8) @(posedge clk);
        `CHK(oe, 1'b1)
        `CHK({pad, ev}, 2'b00)
        pd <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK({oe, core_en}, 2'b00)
        pd <= 1'b0;
        $display("test pad done");
        wr(cmpc_pkg::ADDR_CTRL, 32'h0);
        wr(cmpc_pkg::ADDR_INSEL, 32'h0);
        wr(cmpc_pkg::ADDR_CTRL, 32'hc1);
        repeat (8) @(posedge clk);
        wr(cmpc_pkg::ADDR_STATUS, 32'h1);
        `CHK(pad, 1'b1)
        sb <= 1'b1;
        pos <= 8'h10;
        repeat (8) @(posedge clk);
        `CHK(core_en, 1'b1)
        `CHK({pad, ev}, 2'b00)
        `CHK(irq, 1'b0)
        sb <= 1'b0;
        wr(cmpc_pkg::ADDR_CTRL, 32'h01);
        sb <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK(core_en, 1'b0)
        sb <= 1'b0;
        $display("test standby done");
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
